// file: pkg/svd_pkg.sv
// Package with register map, field positions and timing for the detector.
package svd_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] MASK_OFS     = 8'h08;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  // ==========================================================================
  // Control register fields
  localparam int LEVEL_LSB  = 0;
  localparam int LEVEL_W    = 4;
  localparam int ENABLE_BIT = 4;
  localparam int REFST_BIT  = 5;
  localparam int BGST_BIT   = 6;
  localparam int DIR_BIT    = 7;
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hF;
  // ==========================================================================
  // Status and mask fields
  localparam int EVT_BIT  = 0;
  localparam int WAKE_BIT = 1;
  localparam int IRQ_W    = 2;
  // ==========================================================================
  // Settling time
  localparam int CLK_HZ         = 10000000;
  localparam int SETTLE_TIME_US = 20;
  localparam int SETTLE_CYCLES  =
    (SETTLE_TIME_US * (CLK_HZ / 1000000) < 1) ? 1 :
    SETTLE_TIME_US * (CLK_HZ / 1000000);
  localparam int SETTLE_W       = 16;
endpackage

// file: pkg/svd_sync_if.sv
// Interface carrying synchronised analog indications between modules.
`timescale 1ns/1ps
interface svd_sync_if;
  logic cmp_sync;
  logic bg_sync;
  logic settled_sync;
  modport src (output cmp_sync, output bg_sync, output settled_sync);
  modport dst (input cmp_sync, input bg_sync, input settled_sync);
endinterface

// file: hw/svd_sync2.sv
// Two-flop synchroniser for one level.
`timescale 1ns/1ps
module svd_sync2 (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic ce_in,
  // Data
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= 1'b0;
      q_out  <= 1'b0;
    end else if (ce_in) begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule // svd_sync2

// file: hw/svd_settle.sv
// Settling timer started on each rising edge of the enable.
`timescale 1ns/1ps
module svd_settle #(
  parameter int CYCLES = svd_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic ce_in,
  // Control
  input  wire logic enable_in,
  input  wire logic ext_settled_in,
  output logic      stable_out
);
  logic [svd_pkg::SETTLE_W-1:0] cnt_q;
  logic                         en_prev_q;
  logic                         done_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q     <= '0;
      en_prev_q <= 1'b0;
      done_q    <= 1'b0;
    end else if (ce_in) begin
      en_prev_q <= enable_in;
      if (!enable_in) begin
        cnt_q  <= '0;
        done_q <= 1'b0;
      end else if (!en_prev_q) begin
        cnt_q  <= '0;      // see RQ17
        done_q <= 1'b0;
      end else if (cnt_q != CYCLES[svd_pkg::SETTLE_W-1:0]) begin
        cnt_q <= cnt_q + 1'b1;  // see RQ12
      end else begin
        done_q <= 1'b1;
      end
    end
  end

  // Both the fixed time and the analog settled indication must agree.
  assign stable_out = done_q & ext_settled_in; // see RQ2
endmodule // svd_settle

// file: hw/svd_ctrl.sv
// Supply voltage detector control, event logic and AHB-Lite register slave.
// Function
// RQ1 - Enable bit 4 turns the detector on and off.
// RQ2 - Reference-stable bit 5 stays low after enable until settled.
// RQ3 - No event flag or interrupt while reference-stable is clear.
// RQ4 - Bit 7 zero: at or below trip; one: above trip.
// RQ5 - Compare result in programmed direction sets the event flag.
// RQ6 - Bits 3..0 choose one of 16 trip levels for the comparator.
// RQ7 - Level all ones routes the external trip pin to the comparator.
// RQ8 - Bit 6 reports band gap references stable, read only.
// RQ9 - Bits 6,5 read only reset zero; other fields read/write reset zero.
// RQ10 - Software sets level, direction, enable, clears flag, then unmasks.
// RQ11 - Software disables before changing direction or level.
// RQ12 - Settling interval is a fixed time, not clock dependent; here SETTLE_CYCLES enabled clock cycles, 20 us only at 10 MHz.
// RQ13 - Detector keeps running in sleep and requests wake-up on event.
// RQ14 - Reset clears the control register and turns detector off.
// RQ15 - Event flag blocked until settling time elapsed and reference stable.
// RQ16 - Comparator result passes a two-stage synchroniser before use.
// RQ17 - Settling counter restarts on each rising edge of enable.
// RQ18 - Event flag stays set until software clears it.
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module svd_ctrl #(
  parameter int SETTLE_CYCLES = svd_pkg::SETTLE_CYCLES
) (
  // Clock, reset and clock enable
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Analog side
  input  wire logic        cmp_result_in,
  input  wire logic        bandgap_ok_in,
  input  wire logic        ref_settled_in,
  output logic [3:0]       trip_level_select_out,
  output logic             external_trip_input_sel_out,
  output logic             trip_direction_select_out,
  output logic             detector_enable_out,
  // System
  input  wire logic        sleep_in,
  output logic             wake_req_out,
  output logic             irq_out
);
  // ==========================================================================
  // Synchronisers
  svd_sync_if sif ();

  svd_sync2 u_sync_cmp (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .ce_in   (ce_in),
    .d_in    (cmp_result_in),
    .q_out   (sif.cmp_sync)
  ); // see RQ16

  svd_sync2 u_sync_bg (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .ce_in   (ce_in),
    .d_in    (bandgap_ok_in),
    .q_out   (sif.bg_sync)
  );

  svd_sync2 u_sync_settled (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .ce_in   (ce_in),
    .d_in    (ref_settled_in),
    .q_out   (sif.settled_sync)
  );

  // ==========================================================================
  // Control register
  logic [3:0] level_q;
  logic       dir_q;
  logic       enable_q;
  logic       ref_stable;
  logic [svd_pkg::IRQ_W-1:0] status_q;
  logic [svd_pkg::IRQ_W-1:0] mask_q;

  // ==========================================================================
  // AHB-Lite address phase capture
  logic       wr_pend_q;
  logic [7:0] addr_q;
  logic       access;

  assign access = hsel_in & htrans_in[1] & hready_in;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else if (ce_in) begin
      if (hready_in) begin
        wr_pend_q <= access & hwrite_in;
        addr_q    <= haddr_in[7:0];
      end
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  logic       wr_ctrl;
  logic       wr_status;
  logic       wr_mask;
  assign wr_ctrl   = wr_pend_q & (addr_q == svd_pkg::CTRL_OFS);
  assign wr_status = wr_pend_q & (addr_q == svd_pkg::STATUS_OFS);
  assign wr_mask   = wr_pend_q & (addr_q == svd_pkg::MASK_OFS);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      level_q  <= 4'h0;   // see RQ14
      dir_q    <= 1'b0;
      enable_q <= 1'b0;
    end else if (ce_in && wr_ctrl) begin
      level_q  <= hwdata_in[svd_pkg::LEVEL_LSB +: svd_pkg::LEVEL_W]; // see RQ6
      dir_q    <= hwdata_in[svd_pkg::DIR_BIT];                       // see RQ4
      enable_q <= hwdata_in[svd_pkg::ENABLE_BIT];                    // see RQ1
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mask_q <= '0;
    end else if (ce_in && wr_mask) begin
      mask_q <= hwdata_in[svd_pkg::IRQ_W-1:0];
    end
  end

  // ==========================================================================
  // Settling timer
  svd_settle #(
    .CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .clk_in         (clk_in),
    .rstn_in        (rstn_in),
    .ce_in          (ce_in),
    .enable_in      (enable_q),
    .ext_settled_in (sif.settled_sync),
    .stable_out     (ref_stable)
  ); // see RQ17

  // ==========================================================================
  // Event detection
  // The comparator reports supply above the trip point as high.
  logic hit;
  logic sleep_q;
  assign hit = enable_q & ref_stable &                 // see RQ3
               (dir_q ? sif.cmp_sync : ~sif.cmp_sync); // see RQ4

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sleep_q <= 1'b0;
    end else if (ce_in) begin
      sleep_q <= sleep_in;
    end
  end

  // Set wins over a clear in the same cycle, so no event is lost.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_q <= '0;
    end else if (ce_in) begin
      if (wr_status) begin
        status_q <= status_q & ~hwdata_in[svd_pkg::IRQ_W-1:0]; // see RQ18
      end
      if (hit) begin
        status_q[svd_pkg::EVT_BIT] <= 1'b1;  // see RQ5 RQ15
      end
      if (hit && sleep_q) begin
        status_q[svd_pkg::WAKE_BIT] <= 1'b1; // see RQ13
      end
    end
  end

  assign irq_out      = |(status_q & mask_q);
  assign wake_req_out = sleep_q & status_q[svd_pkg::EVT_BIT]; // see RQ13

  // ==========================================================================
  // Analog controls
  assign trip_level_select_out       = level_q;                // see RQ6
  assign external_trip_input_sel_out =
    (level_q == svd_pkg::LEVEL_EXTERNAL);                      // see RQ7
  assign trip_direction_select_out   = dir_q;
  assign detector_enable_out         = enable_q;               // see RQ1

  // ==========================================================================
  // Read data, registered in the data phase.
  logic [7:0] ctrl_rd;
  always_comb begin
    ctrl_rd = svd_pkg::CTRL_RESET;
    ctrl_rd[svd_pkg::LEVEL_LSB +: svd_pkg::LEVEL_W] = level_q;
    ctrl_rd[svd_pkg::ENABLE_BIT] = enable_q;
    ctrl_rd[svd_pkg::REFST_BIT]  = enable_q & ref_stable;      // see RQ2 RQ9
    ctrl_rd[svd_pkg::BGST_BIT]   = sif.bg_sync;                // see RQ8
    ctrl_rd[svd_pkg::DIR_BIT]    = dir_q;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (ce_in && access && !hwrite_in) begin
      case (haddr_in[7:0])
        svd_pkg::CTRL_OFS:   hrdata_out <= {24'h00_0000, ctrl_rd};
        svd_pkg::STATUS_OFS: hrdata_out <= {30'h0000_0000, status_q};
        svd_pkg::MASK_OFS:   hrdata_out <= {30'h0000_0000, mask_q};
        default:             hrdata_out <= 32'h0000_0000;
      endcase
    end
  end
endmodule // svd_ctrl

// file: testbench/svd_ctrl_sva.sv
// Port checker for the supply voltage detector control block.
`timescale 1ns/1ps
// ============================================================
// Checker
module svd_ctrl_sva #(parameter int SETTLE_CYCLES = 5) (
  // Inputs
  input wire logic       clk_in,
  input wire logic       rstn_in,
  input wire logic       hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic       hwrite_in,
  input wire logic       hready_in,
  input wire logic       sleep_in,
  // Outputs
  input wire logic [3:0] trip_level_select_out,
  input wire logic       external_trip_input_sel_out,
  input wire logic       trip_direction_select_out,
  input wire logic       detector_enable_out,
  input wire logic       wake_req_out,
  input wire logic       irq_out
);
  logic        wr;
  logic [15:0] on_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // A write lands one edge after its address phase is taken and is seen changed at the edge after that.
  assign wr = hsel_in & htrans_in[1] & hwrite_in & hready_in;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      on_q <= 16'h0000;
    end else begin
      on_q <= detector_enable_out ? on_q + {15'h0000, ~&on_q} : 16'h0000;
    end
  end
  AST_EXT_SEL: assert property (
    external_trip_input_sel_out == (trip_level_select_out == 4'hF))
    else $error("external select disagrees with level");
  AST_RESET_OFF: assert property (
    $rose(rstn_in) |-> !detector_enable_out && !irq_out &&
    trip_level_select_out == 4'h0) else $error("not off after reset");
  AST_EN_WRITE: assert property (
    $changed(detector_enable_out) |-> $past(wr, 2))
    else $error("enable moved without a write");
  AST_LVL_WRITE: assert property (
    $changed(trip_level_select_out) |-> $past(wr, 2))
    else $error("level moved without a write");
  AST_DIR_WRITE: assert property (
    $changed(trip_direction_select_out) |-> $past(wr, 2))
    else $error("direction moved without a write");
  AST_WAKE: assert property (
    wake_req_out |-> $past(sleep_in)) else $error("wake outside sleep");
  AST_STICKY: assert property (
    $fell(irq_out) |-> $past(wr, 2) || $past(wr, 3))
    else $error("interrupt dropped without a write");
  AST_SETTLE: assert property (
    $rose(irq_out) && !$past(wr, 2) && !$past(wr, 3) |->
    on_q >= 16'(SETTLE_CYCLES)) else $error("event before settling");
  AST_EVT_ON: assert property (
    $rose(irq_out) |-> detector_enable_out || $past(wr, 2) ||
    $past(wr, 3)) else $error("event while detector off");
  COV_IRQ: cover property ($rose(irq_out));
  COV_WAKE: cover property ($rose(wake_req_out));
  COV_EN: cover property ($rose(detector_enable_out));
endmodule // svd_ctrl_sva

bind svd_ctrl svd_ctrl_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
  .clk_in, .rstn_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in,
  .sleep_in, .trip_level_select_out, .external_trip_input_sel_out,
  .trip_direction_select_out, .detector_enable_out, .wake_req_out,
  .irq_out);

// file: testbench/svd_analog_model.sv
// Behavioural model of the comparator, reference and trip pin.
`timescale 1ns/1ps
// ============================================================
// Analog model
module svd_analog_model (
  // Control
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic en_in,
  input  wire logic ext_sel_in,
  input  wire logic supply_hi_in,
  input  wire logic ext_hi_in,
  // Indications
  output logic      cmp_out,
  output logic      settled_out
);
  logic [2:0] age_q;
  logic       junk_q;
  // Fixed start-up delay, cleared on the next clock edge when powered off.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      age_q  <= 3'h0;
      junk_q <= 1'b0;
    end else begin
      age_q  <= en_in ? age_q + {2'h0, ~&age_q} : 3'h0;
      junk_q <= ~junk_q;
    end
  end
  assign settled_out = age_q >= 3'h3;
  // An unpowered comparator says nothing useful, so it toggles.
  assign cmp_out = !en_in ? junk_q :
                   (ext_sel_in ? ext_hi_in : supply_hi_in);
endmodule // svd_analog_model

// file: testbench/svd_ctrl_tb.sv
// Self-checking testbench for the detector control block.
`timescale 1ns/1ps
// ============================================================
// Testbench
module svd_ctrl_tb;
  logic        clk_in, rstn_in, hsel_in, hwrite_in, sleep_in, sup_hi;
  logic [1:0]  htrans_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, q;
  logic [3:0]  trip_level_select_out;
  logic        hreadyout_out, hresp, cmp, stl, wake_req_out, irq_out, ext_hi;
  logic        external_trip_input_sel_out, detector_enable_out, dir;
  int          fail_count = 0;
  int          compares = 0;
  svd_ctrl #(.SETTLE_CYCLES(5)) i_dut (
    .clk_in, .rstn_in, .ce_in(1'b1), .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out),
    .hrdata_out, .hreadyout_out, .hresp_out(hresp), .cmp_result_in(cmp),
    .bandgap_ok_in(stl), .ref_settled_in(stl), .trip_level_select_out,
    .external_trip_input_sel_out, .trip_direction_select_out(dir),
    .detector_enable_out, .sleep_in, .wake_req_out, .irq_out);
  svd_analog_model u_ana (
    .clk_in, .rstn_in, .en_in(detector_enable_out),
    .ext_sel_in(external_trip_input_sel_out), .supply_hi_in(sup_hi),
    .ext_hi_in(ext_hi), .cmp_out(cmp), .settled_out(stl));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    haddr_in  <= {24'h000000, a};
    hwrite_in <= w;
    htrans_in <= 2'h2;
    hsel_in   <= 1'b1;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hsel_in   <= 1'b0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    q = hrdata_out;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  task automatic summarize();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    summarize();
  end
  initial begin
    {rstn_in, hsel_in, hwrite_in, sleep_in, sup_hi, ext_hi, htrans_in} = '0;
    {haddr_in, hwdata_in} = '0;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    bus(8'h00, 1'b1, 32'h6F);
    rd(8'h00, 32'h0F);
    for (int l = 0; l < 16; l++) begin
      bus(8'h00, 1'b1, 32'(l));
      @(posedge clk_in);
      chk({27'h0, external_trip_input_sel_out, trip_level_select_out},
          {27'h0, l == 15, 4'(l)});
    end
    // Enter sleep low on supply; nothing may fire while settling.
    sleep_in <= 1'b1;
    bus(8'h00, 1'b1, 32'h15);
    rd(8'h00, 32'h15);
    rd(8'h04, 32'h0);
    repeat (20) @(posedge clk_in);
    rd(8'h00, 32'h75);
    rd(8'h04, 32'h3);
    chk({31'h0, wake_req_out}, 32'h1);
    sleep_in <= 1'b0;
    sup_hi <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd(8'h04, 32'h3);
    chk({31'h0, irq_out}, 32'h0);
    bus(8'h08, 1'b1, 32'h1);
    @(posedge clk_in);
    chk({31'h0, irq_out}, 32'h1);
    bus(8'h00, 1'b1, 32'h05);
    bus(8'h04, 1'b1, 32'h3);
    rd(8'h04, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    // Rising-edge detection, set up in the advised order.
    sup_hi <= 1'b0;
    bus(8'h00, 1'b1, 32'h85);
    bus(8'h00, 1'b1, 32'h95);
    rd(8'h00, 32'h95);
    chk({29'h0, hresp, dir, detector_enable_out}, 32'h3);
    repeat (20) @(posedge clk_in);
    rd(8'h04, 32'h0);
    sup_hi <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd(8'h04, 32'h1);
    chk({31'h0, irq_out}, 32'h1);
    // External trip pin: the supply path must be ignored at level 15.
    bus(8'h00, 1'b1, 32'h8F);
    bus(8'h00, 1'b1, 32'h9F);
    bus(8'h04, 1'b1, 32'h3);
    repeat (20) @(posedge clk_in);
    rd(8'h04, 32'h0);
    ext_hi <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd(8'h04, 32'h1);
    chk({31'h0, irq_out}, 32'h1);
    rstn_in <= 1'b0;
    @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    rd(8'h00, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    summarize();
  end
endmodule // svd_ctrl_tb
